// ===== rcad_rx_align.sv
// Receive comma aligner with two 8b/10b decoders and a two-entry buffer.
// Assumes RX_WORD changes away from the rising edge of RX_WORD_CLK and
// that RX_WORD_CLK is well below half of CLK.
`default_nettype none

module rcad_rx_align (
	input  wire logic                        CLK,
	input  wire logic                        RESETN,
	input  wire logic                        RX_WORD_CLK,
	input  wire logic [rcad_pkg::WORD_W-1:0] RX_WORD,
	input  wire logic                        DECODE_ENABLE_PIN,
	input  wire logic                        RX_RATE_SELECT_PIN,
	input  wire logic                        RX_READY,
	output var  logic [rcad_pkg::WORD_W-1:0] RX_DATA,
	output var  logic [rcad_pkg::WORD_W-1:0] RX_DATA_OE,
	output var  logic                        RX_VALID,
	output var  logic                        RX_SYNC,
	output var  logic                        RX_OVERRUN
);
	import rcad_pkg::*;

	// ****************************************
	// Code group decoder
	// ****************************************
	// Result is {error, K flag, byte}; no running disparity check
	function automatic logic [9:0] dec(input logic [9:0] g);
		logic [9:0] r;
		logic [5:0] s6;
		logic [3:0] s4;
		logic [3:0] c4;
		logic [4:0] x;
		logic [2:0] y;
		logic       hx;
		logic       hy;
		logic       k;
		r  = '0;
		x  = '0;
		y  = '0;
		hx = 1'b0;
		hy = 1'b0;
		k  = 1'b0;
		for (int i = 0; i < CODE_W; i++) begin
			r[CODE_W-1-i] = g[i];
		end
		s6 = r[9:4];
		s4 = r[3:0];
		for (int d = 0; d < 32; d++) begin
			if (s6 == ENC6[d] || (s6 == ~ENC6[d] &&
			    (d == 7 || $countones(ENC6[d]) != 3))) begin
				x  = 5'(d);
				hx = 1'b1;
			end
		end
		if (s6 == K28_6B || s6 == ~K28_6B) begin
			x  = K28_IDX;
			hx = 1'b1;
			for (int j = 0; j < 8; j++) begin
				c4 = (s6 == K28_6B) ? ~K28_4B[j] : K28_4B[j];
				if (s4 == c4) begin
					y  = 3'(j);
					hy = 1'b1;
					k  = 1'b1;
				end
			end
		end else if (s4 == ALT7_4B || s4 == ~ALT7_4B) begin
			// Alternate x.7 form: K23/27/29/30.7 or a few data codes
			y  = 3'h7;
			hy = hx && (K7_SET[x] || A7_SET[x]);
			k  = K7_SET[x];
		end else begin
			for (int j = 0; j < 8; j++) begin
				c4 = ENC4[j];
				if (s4 == c4 || (s4 == ~c4 &&
				    (j == 3 || $countones(c4) != 2))) begin
					y  = 3'(j);
					hy = 1'b1;
				end
			end
		end
		if (hx && hy) begin
			return {1'b0, k, y, x};
		end
		return {1'b1, 1'b1, ERR_BYTE};
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [2:0]        lclk;
	logic [WORD_W-1:0] word_s1;
	logic [WORD_W-1:0] word_s2;
	logic [1:0]        pin_s1;
	logic              dec_s2;
	logic              full;
	logic              strobe;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			lclk    <= '0;
			word_s1 <= '0;
			word_s2 <= '0;
			pin_s1  <= '0;
			dec_s2  <= 1'b0;
			full    <= 1'b0;
		end else begin
			lclk    <= {lclk[1:0], RX_WORD_CLK};
			word_s1 <= RX_WORD;
			word_s2 <= word_s1;
			pin_s1  <= {RX_RATE_SELECT_PIN, DECODE_ENABLE_PIN};
			dec_s2  <= pin_s1[0];
			full    <= pin_s1[1];
		end
	end

	// Data and clock share the same depth, so the pairing holds
	assign strobe = lclk[1] && !lclk[2];

	// ****************************************
	// Comma search and alignment
	// ****************************************
	logic [WIN_W-1:0]  win;
	logic [WORD_W-1:0] prev;
	logic [WORD_W-1:0] next_prev;
	logic [WORD_W-1:0] al;
	logic [4:0]        off;
	logic [4:0]        next_off;
	logic [4:0]        sel_off;
	logic [4:0]        pos;
	logic              found;
	logic              next_sync;

	always_comb begin
		if (full) begin
			win = {word_s2, prev};
		end else begin
			win = WIN_W'({word_s2[CODE_W-1:0], prev[CODE_W-1:0]});
		end
		found = 1'b0;
		pos   = '0;
		// Downward scan so the earliest comma wins
		for (int p = WORD_W - 1; p >= 0; p--) begin
			if ((full || p < CODE_W) && win[p +: 7] == COMMA_POS) begin
				found = 1'b1;
				pos   = 5'(p);
			end
		end
		if (found) begin
			sel_off = pos;
		end else if (!full && off >= 5'(CODE_W)) begin
			sel_off = '0;
		end else begin
			sel_off = off;
		end
		al        = WORD_W'(win >> sel_off);
		next_off  = strobe ? sel_off : off;
		next_prev = strobe ? word_s2 : prev;
		next_sync = RX_SYNC || (strobe && found);
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			off     <= '0;
			prev    <= '0;
			RX_SYNC <= 1'b0;
		end else begin
			off     <= next_off;
			prev    <= next_prev;
			RX_SYNC <= next_sync;
		end
	end

	// ****************************************
	// Decoders and bus mapping
	// ****************************************
	logic [9:0]        lane [2];
	logic [WORD_W-1:0] bus_d;
	logic [WORD_W-1:0] bus_oe;

	for (genvar i = 0; i < 2; i++) begin : g_lane
		assign lane[i] = dec(al[i*CODE_W +: CODE_W]);
	end

	always_comb begin
		bus_d  = al;
		bus_oe = OE_FULL_RAW;
		if (dec_s2) begin
			bus_d = {2'b00, lane[1][8], lane[0][8],
			         lane[1][7:0], lane[0][7:0]};
			bus_oe = OE_FULL_DEC;
		end
		if (!full) begin
			bus_oe = dec_s2 ? OE_HALF_DEC : OE_HALF_RAW;
			bus_d  = bus_d & bus_oe;
		end
	end

	// ****************************************
	// Capture register and two-entry buffer
	// ****************************************
	// The link cannot be paused: a word meeting a full path is dropped
	// and flagged rather than silently overwriting a held one.
	logic              cap_v;
	logic              next_cap_v;
	logic [WORD_W-1:0] cap_d;
	logic [WORD_W-1:0] next_cap_d;
	logic [WORD_W-1:0] cap_oe;
	logic [WORD_W-1:0] next_cap_oe;
	logic              sv;
	logic              next_sv;
	logic [WORD_W-1:0] sd;
	logic [WORD_W-1:0] next_sd;
	logic [WORD_W-1:0] soe;
	logic [WORD_W-1:0] next_soe;
	logic              next_ov;
	logic [WORD_W-1:0] next_od;
	logic [WORD_W-1:0] next_ooe;
	logic              next_overrun;
	logic              take;
	logic              load;

	always_comb begin
		take         = cap_v && !sv;
		load         = strobe && (!cap_v || take);
		next_cap_v   = load || (cap_v && !take);
		next_cap_d   = load ? bus_d : cap_d;
		next_cap_oe  = load ? bus_oe : cap_oe;
		next_overrun = strobe && !load;
		next_ov      = RX_VALID;
		next_od      = RX_DATA;
		next_ooe     = RX_DATA_OE;
		next_sv      = sv;
		next_sd      = sd;
		next_soe     = soe;
		if (!RX_VALID || RX_READY) begin
			if (sv) begin
				next_ov  = 1'b1;
				next_od  = sd;
				next_ooe = soe;
				next_sv  = 1'b0;
			end else begin
				next_ov = take;
				if (take) begin
					next_od  = cap_d;
					next_ooe = cap_oe;
				end
			end
		end else if (take) begin
			next_sv  = 1'b1;
			next_sd  = cap_d;
			next_soe = cap_oe;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cap_v      <= 1'b0;
			cap_d      <= '0;
			cap_oe     <= '0;
			sv         <= 1'b0;
			sd         <= '0;
			soe        <= '0;
			RX_VALID   <= 1'b0;
			RX_DATA    <= '0;
			RX_DATA_OE <= '0;
			RX_OVERRUN <= 1'b0;
		end else begin
			cap_v      <= next_cap_v;
			cap_d      <= next_cap_d;
			cap_oe     <= next_cap_oe;
			sv         <= next_sv;
			sd         <= next_sd;
			soe        <= next_soe;
			RX_VALID   <= next_ov;
			RX_DATA    <= next_od;
			RX_DATA_OE <= next_ooe;
			RX_OVERRUN <= next_overrun;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	property p_half_raw;
		load && !full && !dec_s2 |=>
			cap_oe == OE_HALF_RAW && cap_d[19:10] == '0;
	endproperty
	a_half_raw: assert property (p_half_raw)
		else $error("half rate raw lane map wrong");

	property p_half_dec;
		load && !full && dec_s2 |=> cap_oe == OE_HALF_DEC;
	endproperty
	a_half_dec: assert property (p_half_dec)
		else $error("half rate decoded lane map wrong");

	property p_full_dec;
		load && full && dec_s2 |=> cap_oe == OE_FULL_DEC;
	endproperty
	a_full_dec: assert property (p_full_dec)
		else $error("full rate decoded lane map wrong");

	property p_full_raw;
		load && full && !dec_s2 |=>
			cap_oe == OE_FULL_RAW && cap_d == $past(al);
	endproperty
	a_full_raw: assert property (p_full_raw)
		else $error("full rate raw word wrong");

	property p_err;
		load && dec_s2 && lane[0][9] |=>
			cap_d[16] && cap_d[7:0] == ERR_BYTE;
	endproperty
	a_err: assert property (p_err)
		else $error("bad code not reported as K0.0");

	property p_kflag;
		load && full && dec_s2 |=>
			cap_d[17] == $past(lane[1][8]) &&
			cap_d[16] == $past(lane[0][8]);
	endproperty
	a_kflag: assert property (p_kflag)
		else $error("K flag does not follow decoder");

	property p_hold;
		strobe && !found && (full || off < 5'(CODE_W)) |=>
			off == $past(off);
	endproperty
	a_hold: assert property (p_hold)
		else $error("boundary moved without a comma");

	property p_lock;
		strobe && found |=> off == $past(pos) && RX_SYNC;
	endproperty
	a_lock: assert property (p_lock)
		else $error("boundary not taken from comma");

	property p_comma_low;
		load && found && !dec_s2 |=> cap_d[6:0] == COMMA_POS;
	endproperty
	a_comma_low: assert property (p_comma_low)
		else $error("comma not at low end of word");

	property p_stall;
		RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA);
	endproperty
	a_stall: assert property (p_stall)
		else $error("output changed while stalled");

	c_full_dec: cover property (load && full && dec_s2);
	c_half_raw: cover property (load && !full && !dec_s2);
	c_skid: cover property (sv && !RX_READY);
	c_err: cover property (load && dec_s2 && lane[0][9]);
endmodule

`default_nettype wire

// ===== rcad_pkg.sv
// Constants and code tables for the receive comma aligner and decoder.
// Assumes a 10 MHz system clock and a sampled, slower recovered word clock.
// Summary of operation
// - Two decoders each turn one 10-bit half of the word into a byte.
// - A comma search fixes the group boundary and puts the comma at the LSB.
// - Besides half rate clearing an offset of 10 or more to 0, only the 0011111 comma moves the boundary, never its complement.
// - The decoder results go to a 20-bit register, valid per word clock.
// - Decoding on: bit 16 is high for a K low byte, low for D; byte on 0..7.
// - Full rate, decoding on: bit 17 flags the high byte K, byte on 8..15.
// - A bad group, or a K code not allowed, reads as K0.0 in that byte only.
// - Only K28.0-K28.7, K23.7, K27.7, K29.7 and K30.7 are valid K codes.
// - Decode pin low drives raw code bits; high drives bytes and flags.
// - The rate pin picks 20-bit words (full rate) or 10-bit words (half).
// - Receive rate is chosen with no tie to any transmit rate setting.
// - Half-rate raw mode drives the group on bits 0..9, floats 10..19.
// - Half-rate decoded drives bits 0..7 and 16, floats 8..15 and 17..19.
// - Full-rate raw drives all 20 bits, first bit received on bit 0.
// - Full-rate decoded: earlier group low, later high, floats 18..19.
// - At full rate the boundary puts a comma K28.5 in the low byte.
`default_nettype none

package rcad_pkg;
	localparam int WORD_W = 20;
	localparam int CODE_W = 10;
	localparam int WIN_W  = 40;
	// Comma bits in arrival order, first bit at the LSB
	localparam logic [6:0] COMMA_POS = 7'h7C;
	localparam logic [7:0] ERR_BYTE = 8'h00;
	localparam logic [5:0] K28_6B = 6'h0F;
	localparam logic [4:0] K28_IDX = 5'h1C;
	localparam logic [3:0] ALT7_4B = 4'h7;
	localparam logic [31:0] K7_SET = 32'h6880_0000;
	localparam logic [31:0] A7_SET = 32'h0016_6800;
	// 6b and 4b codes for negative disparity, first bit at the MSB
	localparam logic [5:0] ENC6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] ENC4 [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	// K28 4b codes after the positive 6b half
	localparam logic [3:0] K28_4B [8] = '{
		4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};
	localparam logic [19:0] OE_FULL_RAW = 20'hF_FFFF;
	localparam logic [19:0] OE_FULL_DEC = 20'h3_FFFF;
	localparam logic [19:0] OE_HALF_RAW = 20'h0_03FF;
	localparam logic [19:0] OE_HALF_DEC = 20'h1_00FF;
endpackage

`default_nettype wire

// ===== rcad_host_model.sv
// Host side model: takes words off the receive bus, stalling at random.
// Assumes the bench raises STALL to hold ready low for a long stall.
`default_nettype none

module rcad_host_model (
	input  wire logic                        CLK,
	input  wire logic                        RESETN,
	input  wire logic                        RX_VALID,
	input  wire logic [rcad_pkg::WORD_W-1:0] RX_DATA,
	input  wire logic [rcad_pkg::WORD_W-1:0] RX_DATA_OE,
	input  wire logic                        STALL,
	output var  logic                        RX_READY
);
	timeunit 1ns;
	timeprecision 1ns;
	import rcad_pkg::*;
	logic [39:0] got [$];
	// Random short stalls must never overrun the two-entry buffer
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RX_READY <= 1'b0;
		end else begin
			if (RX_VALID && RX_READY)
				got.push_back({RX_DATA_OE, RX_DATA});
			RX_READY <= #1 !STALL && ($urandom % 4 != 0);
		end
	end
endmodule

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the receive comma aligner and decoder.
// Assumes rcad_pkg and the host model are compiled first.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import rcad_pkg::*;
	logic        clk, resetn, wclk, dec, full, stall;
	logic        ready, valid, sync, ovr;
	logic [19:0] word, data, oe;
	logic [9:0]  cq [$];
	logic [8:0]  dq [$];
	logic        bq [$];
	int          fail_count, cmp_count, cyc, novr;
	int          ys [5] = '{0, 1, 2, 5, 6};
	int          xs [4] = '{23, 27, 29, 30};

	rcad_rx_align DUT (
		.CLK(clk), .RESETN(resetn), .RX_WORD_CLK(wclk), .RX_WORD(word),
		.DECODE_ENABLE_PIN(dec), .RX_RATE_SELECT_PIN(full),
		.RX_READY(ready), .RX_DATA(data), .RX_DATA_OE(oe),
		.RX_VALID(valid), .RX_SYNC(sync), .RX_OVERRUN(ovr));
	rcad_host_model host (
		.CLK(clk), .RESETN(resetn), .RX_VALID(valid), .RX_DATA(data),
		.RX_DATA_OE(oe), .STALL(stall), .RX_READY(ready));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(negedge clk) begin
		cyc++;
		if (ovr === 1'b1)
			novr++;
		if (cyc == 60000) begin
			fail_count++;
			end_of_test();
		end
	end

	// ********
	// Checks
	// ********
	task automatic chk_w(logic [39:0] g, logic [39:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic chk_b(logic g, logic e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("Error %0t: flag %b, expected %b", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("Compares %0d, errors %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Expected {OE, data} for output unit i
	function automatic logic [39:0] expw(int i, logic d, logic f);
		logic [9:0] cl, ch;
		logic [8:0] dl, dh;
		if (f) begin
			cl = cq[2 * i];
			ch = cq[2 * i + 1];
			dl = dq[2 * i];
			dh = dq[2 * i + 1];
		end else begin
			cl = cq[i];
			ch = 10'h000;
			dl = dq[i];
			dh = 9'h000;
		end
		case ({f, d})
			2'h3: return {OE_FULL_DEC, 2'h0, dh[8], dl[8], dh[7:0], dl[7:0]};
			2'h2: return {OE_FULL_RAW, ch, cl};
			2'h1: return {OE_HALF_DEC, 3'h0, dl[8], 8'h00, dl[7:0]};
			default: return {OE_HALF_RAW, 10'h000, cl};
		endcase
	endfunction

	// ********
	// Stimulus
	// ********
	task automatic add(logic [9:0] c, logic k, logic [7:0] b);
		logic [9:0] r;
		r = {<<{c}};
		cq.push_back(r);
		dq.push_back({k, b});
	endtask
	// Data codes kept clear of false commas across code borders
	task automatic add_d();
		logic [4:0] x;
		logic [2:0] y;
		x = 5'h07;
		while (x inside {5'h07, 5'h08, 5'h17})
			x = 5'($urandom);
		y = 3'(ys[$urandom % 5]);
		add({ENC6[x], ENC4[y]}, 1'b0, {y, x});
	endtask
	task automatic addk7(logic [4:0] x);
		add({ENC6[x], ~ALT7_4B}, 1'b1, {3'h7, x});
	endtask
	task automatic send(logic [19:0] v);
		word = v;
		#400 wclk = 1'b1;
		#400 wclk = 1'b0;
	endtask
	function automatic logic [19:0] slice(int b, int w);
		for (int i = 0; i < 20; i++)
			slice[i] = (i < w) ? bq[b + i] : ~word[i];
	endfunction
	task automatic run(logic d, logic f);
		int p, w, k, s, ne;
		logic [9:0] neg;
		cq.delete();
		dq.delete();
		bq.delete();
		host.got.delete();
		@(posedge clk);
		#1;
		dec = d;
		full = f;
		resetn = 1'b0;
		repeat (5) @(posedge clk);
		#1 resetn = 1'b1;
		w = f ? 20 : 10;
		p = $urandom % w;
		add({K28_6B, ~K28_4B[5]}, 1'b1, {3'h5, K28_IDX});
		add_d();
		for (int y = 0; y < 8; y++) begin
			add({K28_6B, ~K28_4B[y]}, 1'b1, {3'(y), K28_IDX});
			if (y % 2)
				add_d();
			else
				addk7(5'h1B);
		end
		foreach (xs[i]) begin
			addk7(5'(xs[i]));
			add_d();
		end
		add(10'h000, 1'b1, ERR_BYTE);
		add(10'h000, 1'b1, ERR_BYTE);
		add({ENC6[17], ALT7_4B}, 1'b0, {3'h7, 5'h11});
		add({ENC6[5], ~ALT7_4B}, 1'b1, ERR_BYTE);
		add({K28_6B, 4'h0}, 1'b1, ERR_BYTE);
		add_d();
		repeat (8) add_d();
		ne = cq.size() / (w / 10);
		repeat (6) add_d();
		neg = {<<{~K28_6B, K28_4B[5]}};
		for (int i = 0; i < p; i++)
			bq.push_back(1'(i % 2));
		for (int i = 0; i < 40; i++)
			bq.push_back(neg[i % 10]);
		foreach (cq[i])
			for (int j = 0; j < 10; j++)
				bq.push_back(cq[i][j]);
		for (k = 0; k < (p + 40) / w; k++)
			send(slice(k * w, w));
		repeat (4) @(posedge clk);
		#1;
		chk_b(sync, 1'b0);
		for (; k * w + w <= bq.size(); k++)
			send(slice(k * w, w));
		repeat (40) @(posedge clk);
		#1;
		chk_b(sync, 1'b1);
		s = -1;
		foreach (host.got[i])
			if (s < 0 && host.got[i] === expw(0, d, f))
				s = i;
		// No aligned first word: compare from the start so it fails
		if (s < 0)
			s = 0;
		for (int i = 0; i < ne; i++)
			chk_w(host.got[s+i], expw(i,d,f));
	endtask

	initial begin
		void'($urandom(32'h83fc_58a7));
		resetn = 1'b0;
		wclk = 1'b0;
		word = 20'h0_0000;
		dec = 1'b0;
		full = 1'b0;
		stall = 1'b0;
		for (int m = 0; m < 4; m++)
			run(m[0], m[1]);
		chk_b(novr == 0, 1'b1);
		#1 stall = 1'b1;
		repeat (6) send(20'($urandom));
		chk_b(valid, 1'b1);
		chk_b(novr > 0, 1'b1);
		stall = 1'b0;
		repeat (40) @(posedge clk);
		#1;
		chk_b(valid, 1'b0);
		end_of_test();
	end
endmodule

`default_nettype wire
